//--- rtl/usbi_pkg.sv
package usbi_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int RESUME_NS = 2500;        // k-state, bus reset, attach quiet time
  localparam int IDLE_MS = 3;             // continuous idle before the idle flag
  localparam int LINE_MS = 1;             // line state stable time
  // least times round up to whole cycles
  localparam int K_CYC = (RESUME_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_CYC_DEF = IDLE_MS * (CLK_HZ / 1000);
  localparam int LINE_CYC_DEF = LINE_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 18;
  typedef logic [CNT_W-1:0] usbi_cnt_t;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [31:0] OFF_OTG_ST = 32'h0000_0000;
  localparam logic [31:0] OFF_OTG_EN = 32'h0000_0004;
  localparam logic [31:0] OFF_USB_ST = 32'h0000_0008;
  localparam logic [31:0] OFF_USB_EN = 32'h0000_000c;
  localparam logic [31:0] OFF_ERR_ST = 32'h0000_0010;
  localparam logic [31:0] OFF_ERR_EN = 32'h0000_0014;
  localparam logic [31:0] OFF_TOK_ST = 32'h0000_0018;
  localparam logic [31:0] OFF_CTRL = 32'h0000_001c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_STALL = 7;
  localparam int BIT_ATTACH = 6;
  localparam int BIT_RESUME = 5;
  localparam int BIT_IDLE = 4;
  localparam int BIT_TOKEN = 3;
  localparam int BIT_SOF = 2;
  localparam int BIT_ERR = 1;
  localparam int BIT_RESET = 0;
  localparam int BIT_ID = 7;
  localparam int BIT_MS = 6;
  localparam int BIT_LINE = 5;
  localparam int BIT_ACT = 4;
  localparam int BIT_SESV = 3;
  localparam int BIT_SESE = 2;
  localparam int BIT_OTG_GAP = 1;
  localparam int BIT_VBUS = 0;
  localparam int BIT_HOST = 0;

  // ****************************************
  // masks, reset values, responses
  // ****************************************
  localparam logic [7:0] OTG_MASK = 8'hfd;
  localparam logic [7:0] ERR_MASK = 8'hbf;
  localparam logic [7:0] DEV_MASK = 8'hbf;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int TOK_DEPTH = 4;
  localparam int TOK_AW = 2;

endpackage

//--- rtl/usbi_tok_fifo.sv
// token status queue; head comes out of a register
module usbi_tok_fifo (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] head,
  output logic [usbi_pkg::TOK_AW:0] count
);

  typedef struct packed {
    logic [usbi_pkg::TOK_DEPTH-1:0][7:0] mem;
    logic [usbi_pkg::TOK_AW-1:0] wp;
    logic [usbi_pkg::TOK_AW-1:0] rp;
    logic [usbi_pkg::TOK_AW:0] cnt;
    logic [7:0] head;
  } usbi_fifo_s;

  usbi_fifo_s fifo_q, fifo_d;
  logic do_pop, do_push;

  // a push into a full queue is dropped unless a pop comes in the same cycle; a pop of an empty one does nothing
  always_comb begin
    fifo_d = fifo_q;
    do_pop = pop && (fifo_q.cnt != '0);
    do_push = push && (fifo_q.cnt != (usbi_pkg::TOK_AW + 1)'(usbi_pkg::TOK_DEPTH) || do_pop);
    if (do_push) begin
      fifo_d.mem[fifo_q.wp] = push_data;
      fifo_d.wp = fifo_q.wp + 1'b1;
    end
    if (do_pop) begin
      fifo_d.rp = fifo_q.rp + 1'b1;
    end
    fifo_d.cnt = fifo_q.cnt + {{usbi_pkg::TOK_AW{1'b0}}, do_push} - {{usbi_pkg::TOK_AW{1'b0}}, do_pop};
    // head shows the entry at the new read pointer, zero when empty
    fifo_d.head = (fifo_d.cnt != '0) ? fifo_d.mem[fifo_d.rp] : usbi_pkg::REG_RST;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_q <= '0;
    end else begin
      fifo_q <= fifo_d;
    end
  end

  assign head = fifo_q.head;
  assign count = fifo_q.cnt;

endmodule

//--- rtl/usbi_flags.sv
module usbi_flags #(
  parameter int IDLE_CYC = usbi_pkg::IDLE_CYC_DEF,
  parameter int LINE_CYC = usbi_pkg::LINE_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_se0,
  input wire logic line_j,
  input wire logic bus_activity,
  input wire logic stall_sent_evt,
  input wire logic token_done_evt,
  input wire logic [7:0] token_stat_in,
  input wire logic sof_evt,
  input wire logic [7:0] err_evt,
  input wire logic id_change_evt,
  input wire logic ms_timer_evt,
  input wire logic session_valid_evt,
  input wire logic session_end_evt,
  input wire logic vbus_valid_evt,
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic aw_v;
    logic [31:0] awaddr;
    logic w_v;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] rd_addr;
    logic host_q;
    logic [7:0] usb_st;
    logic [7:0] usb_en;
    logic [7:0] otg_st;
    logic [7:0] otg_en;
    logic [7:0] err_st;
    logic [7:0] err_en;
    usbi_pkg::usbi_cnt_t k_cnt;
    usbi_pkg::usbi_cnt_t idle_cnt;
    usbi_pkg::usbi_cnt_t se0_cnt;
    usbi_pkg::usbi_cnt_t quiet_cnt;
    usbi_pkg::usbi_cnt_t line_cnt;
    logic [1:0] ls_prev;
    logic [1:0] ls_rec;
    logic irq;
  } usbi_state_s;

  localparam usbi_pkg::usbi_cnt_t K_LIM = usbi_pkg::usbi_cnt_t'(usbi_pkg::K_CYC);
  localparam usbi_pkg::usbi_cnt_t IDLE_LIM = usbi_pkg::usbi_cnt_t'(IDLE_CYC);
  localparam usbi_pkg::usbi_cnt_t LINE_LIM = usbi_pkg::usbi_cnt_t'(LINE_CYC);

  usbi_state_s state_q, state_d;
  logic [7:0] tok_head;
  logic [usbi_pkg::TOK_AW:0] tok_cnt;
  logic wr_go, wr_lo, tok_clr, tok_pop, err_sum;
  logic [7:0] usb_view, en_view;

  // ****************************************
  // helper functions
  // ****************************************
  // saturating run counter: restarts whenever the condition drops
  function automatic usbi_pkg::usbi_cnt_t run_cnt(input logic cond, input usbi_pkg::usbi_cnt_t cnt,
                                                 input usbi_pkg::usbi_cnt_t lim);
    if (!cond) begin
      run_cnt = '0;
    end else if (cnt < lim) begin
      run_cnt = cnt + 1'b1;
    end else begin
      run_cnt = cnt;
    end
  endfunction

  // fires once per run, so a held condition cannot set its flag again
  function automatic logic run_hit(input logic cond, input usbi_pkg::usbi_cnt_t cnt,
                                   input usbi_pkg::usbi_cnt_t lim);
    run_hit = cond && (cnt == lim - 18'h0_0001);
  endfunction

  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a == usbi_pkg::OFF_OTG_ST) || (a == usbi_pkg::OFF_OTG_EN) || (a == usbi_pkg::OFF_USB_ST) ||
                (a == usbi_pkg::OFF_USB_EN) || (a == usbi_pkg::OFF_ERR_ST) || (a == usbi_pkg::OFF_ERR_EN) ||
                (a == usbi_pkg::OFF_TOK_ST) || (a == usbi_pkg::OFF_CTRL);
  endfunction

  // ****************************************
  // token status queue
  // ****************************************
  usbi_tok_fifo u_tok_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(token_done_evt),
    .push_data(token_stat_in),
    .pop(tok_pop),
    .head(tok_head),
    .count(tok_cnt)
  );

  // write strobe and token flag clear seen by the queue
  assign wr_go = state_q.aw_v & state_q.w_v & ~state_q.bvalid;
  assign wr_lo = wr_go & state_q.wstrb[0];
  assign tok_clr = wr_lo & (state_q.awaddr == usbi_pkg::OFF_USB_ST) &
                   state_q.wdata[usbi_pkg::BIT_TOKEN] & state_q.usb_st[usbi_pkg::BIT_TOKEN];
  assign tok_pop = tok_clr & (tok_cnt != '0);

  // views of status and enable with mode-dependent bits folded in
  assign err_sum = |(state_q.err_st & state_q.err_en);
  assign usb_view = {state_q.usb_st[7:2], err_sum, state_q.usb_st[0]} &
                    (state_q.host_q ? 8'hff : usbi_pkg::DEV_MASK);
  assign en_view = state_q.usb_en & (state_q.host_q ? 8'hff : usbi_pkg::DEV_MASK);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] usb_set, usb_clr, otg_set, otg_clr, err_clr, rd_val;
    logic [1:0] ls_cur;
    logic k_on, idle_on, quiet_on, line_hit, se0_hit;
    usb_set = '0;
    usb_clr = '0;
    otg_set = '0;
    otg_clr = '0;
    err_clr = '0;
    rd_val = '0;
    ls_cur = {line_se0, line_j};
    k_on = ~line_se0 & ~line_j;
    idle_on = line_j & ~line_se0 & ~bus_activity;
    quiet_on = ~line_se0 & ~bus_activity;
    line_hit = 1'b0;
    se0_hit = 1'b0;
    state_d = state_q;

    // write address and data are taken independently, in either order
    if (s_axi_awvalid && state_q.awready) begin
      state_d.aw_v = 1'b1;
      state_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_q.wready) begin
      state_d.w_v = 1'b1;
      state_d.wdata = s_axi_wdata;
      state_d.wstrb = s_axi_wstrb;
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      state_d.aw_v = 1'b0;
      state_d.w_v = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = is_mapped(state_q.awaddr) ? usbi_pkg::RESP_OKAY : usbi_pkg::RESP_SLVERR;
    end
    state_d.awready = ~state_d.aw_v & ~state_d.bvalid;
    state_d.wready = ~state_d.w_v & ~state_d.bvalid;

    // register writes; only the low byte lane holds storage, the upper three bytes are dropped
    if (wr_lo) begin
      if (state_q.awaddr == usbi_pkg::OFF_OTG_ST) begin
        otg_clr = state_q.wdata[7:0];
      end else if (state_q.awaddr == usbi_pkg::OFF_OTG_EN) begin
        state_d.otg_en = state_q.wdata[7:0] & usbi_pkg::OTG_MASK;
      end else if (state_q.awaddr == usbi_pkg::OFF_USB_ST) begin
        usb_clr = state_q.wdata[7:0];
      end else if (state_q.awaddr == usbi_pkg::OFF_USB_EN) begin
        state_d.usb_en = state_q.wdata[7:0];
      end else if (state_q.awaddr == usbi_pkg::OFF_ERR_ST) begin
        err_clr = state_q.wdata[7:0];
      end else if (state_q.awaddr == usbi_pkg::OFF_ERR_EN) begin
        state_d.err_en = state_q.wdata[7:0] & usbi_pkg::ERR_MASK;
      end else if (state_q.awaddr == usbi_pkg::OFF_CTRL) begin
        state_d.host_q = state_q.wdata[usbi_pkg::BIT_HOST];
      end
    end

    // line timing detectors
    state_d.k_cnt = run_cnt(k_on, state_q.k_cnt, K_LIM);
    state_d.idle_cnt = run_cnt(idle_on, state_q.idle_cnt, IDLE_LIM);
    state_d.se0_cnt = run_cnt(line_se0, state_q.se0_cnt, K_LIM);
    state_d.quiet_cnt = run_cnt(quiet_on, state_q.quiet_cnt, K_LIM);
    se0_hit = run_hit(line_se0, state_q.se0_cnt, K_LIM);

    // line state must hold still for the whole window and differ from the last recorded one
    state_d.ls_prev = ls_cur;
    state_d.line_cnt = run_cnt(ls_cur == state_q.ls_prev, state_q.line_cnt, LINE_LIM);
    line_hit = run_hit(ls_cur == state_q.ls_prev, state_q.line_cnt, LINE_LIM) && (ls_cur != state_q.ls_rec);
    if (line_hit) begin
      state_d.ls_rec = ls_cur;
    end

    // event sources of the general status
    usb_set[usbi_pkg::BIT_STALL] = stall_sent_evt;
    usb_set[usbi_pkg::BIT_ATTACH] = state_q.host_q && run_hit(quiet_on, state_q.quiet_cnt, K_LIM);
    usb_set[usbi_pkg::BIT_RESUME] = run_hit(k_on, state_q.k_cnt, K_LIM);
    usb_set[usbi_pkg::BIT_IDLE] = run_hit(idle_on, state_q.idle_cnt, IDLE_LIM);
    usb_set[usbi_pkg::BIT_SOF] = sof_evt;
    usb_set[usbi_pkg::BIT_RESET] = se0_hit;

    // set wins over a clear in the same cycle; summary bit is never stored
    state_d.usb_st = (state_q.usb_st & ~usb_clr) | usb_set;
    state_d.usb_st[usbi_pkg::BIT_ERR] = 1'b0;
    // token flag stays up when the queue still holds another entry after the pop
    state_d.usb_st[usbi_pkg::BIT_TOKEN] = token_done_evt | (state_q.usb_st[usbi_pkg::BIT_TOKEN] & ~tok_clr) |
                                          (tok_clr & (tok_cnt > 3'h1));

    // otg and error status
    otg_set[usbi_pkg::BIT_ID] = id_change_evt;
    otg_set[usbi_pkg::BIT_MS] = ms_timer_evt;
    otg_set[usbi_pkg::BIT_LINE] = line_hit;
    otg_set[usbi_pkg::BIT_ACT] = bus_activity;
    otg_set[usbi_pkg::BIT_SESV] = session_valid_evt;
    otg_set[usbi_pkg::BIT_SESE] = session_end_evt;
    otg_set[usbi_pkg::BIT_VBUS] = vbus_valid_evt;
    state_d.otg_st = ((state_q.otg_st & ~otg_clr) | otg_set) & usbi_pkg::OTG_MASK;
    state_d.err_st = ((state_q.err_st & ~err_clr) | err_evt) & usbi_pkg::ERR_MASK;

    // read channel; one read outstanding, data from a register
    if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_q.arready) begin
      if (s_axi_araddr == usbi_pkg::OFF_OTG_ST) begin
        rd_val = state_q.otg_st;
      end else if (s_axi_araddr == usbi_pkg::OFF_OTG_EN) begin
        rd_val = state_q.otg_en;
      end else if (s_axi_araddr == usbi_pkg::OFF_USB_ST) begin
        rd_val = usb_view;
      end else if (s_axi_araddr == usbi_pkg::OFF_USB_EN) begin
        rd_val = en_view;
      end else if (s_axi_araddr == usbi_pkg::OFF_ERR_ST) begin
        rd_val = state_q.err_st;
      end else if (s_axi_araddr == usbi_pkg::OFF_ERR_EN) begin
        rd_val = state_q.err_en;
      end else if (s_axi_araddr == usbi_pkg::OFF_TOK_ST) begin
        rd_val = tok_head;
      end else if (s_axi_araddr == usbi_pkg::OFF_CTRL) begin
        rd_val = {7'h00, state_q.host_q};
      end
      state_d.rvalid = 1'b1;
      state_d.rd_addr = s_axi_araddr;
      state_d.rdata = {24'h00_0000, rd_val};
      state_d.rresp = is_mapped(s_axi_araddr) ? usbi_pkg::RESP_OKAY : usbi_pkg::RESP_SLVERR;
    end
    state_d.arready = ~state_d.rvalid;

    // otg enables only count in host mode; bit 0 covers reset or detach by mode
    state_d.irq = (|(usb_view & en_view)) |
                  (state_q.host_q & (|(state_q.otg_st & state_q.otg_en)));
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = state_q.awready;
  assign s_axi_wready = state_q.wready;
  assign s_axi_bvalid = state_q.bvalid;
  assign s_axi_bresp = state_q.bresp;
  assign s_axi_arready = state_q.arready;
  assign s_axi_rvalid = state_q.rvalid;
  assign s_axi_rdata = state_q.rdata;
  assign s_axi_rresp = state_q.rresp;
  assign irq = state_q.irq;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // idle set condition, so a clear that meets a fresh set is not flagged
  logic idle_on_chk;
  assign idle_on_chk = line_j & ~line_se0 & ~bus_activity && (state_q.idle_cnt == IDLE_LIM - 18'h0_0001);

  irq_follows_a: assert property (((|(usb_view & en_view)) && !state_q.host_q) |=> irq)
    else $error("irq low with enabled flag pending");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper byte of read data not zero");
  dev_bit6_a: assert property ((s_axi_rvalid && !state_q.host_q && state_q.rd_addr == usbi_pkg::OFF_USB_ST &&
                                $past(!state_q.host_q)) |-> !s_axi_rdata[6])
    else $error("status bit 6 read high in device mode");
  stall_set_a: assert property ((stall_sent_evt && !state_q.host_q) |=> state_q.usb_st[usbi_pkg::BIT_STALL])
    else $error("stall flag not set after stall event");
  resume_time_a: assert property ($rose(state_q.usb_st[usbi_pkg::BIT_RESUME]) |->
                                  $past(state_q.k_cnt) == K_LIM - 18'h0_0001)
    else $error("resume flag set without full k-state time");
  err_sum_a: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr == usbi_pkg::OFF_USB_ST) |=>
                              s_axi_rdata[usbi_pkg::BIT_ERR] == $past(err_sum))
    else $error("error summary does not match enabled errors");
  tok_keep_a: assert property ((tok_clr && tok_cnt > 3'h1) |=> state_q.usb_st[usbi_pkg::BIT_TOKEN])
    else $error("token flag lost while queue holds more");
  w1c_clear_a: assert property ((wr_lo && state_q.awaddr == usbi_pkg::OFF_USB_ST &&
                                 state_q.wdata[usbi_pkg::BIT_IDLE] && !(idle_on_chk)) |=>
                                !state_q.usb_st[usbi_pkg::BIT_IDLE])
    else $error("idle flag not cleared by writing one");
  attach_host_a: assert property ($rose(state_q.usb_st[usbi_pkg::BIT_ATTACH]) |-> $past(state_q.host_q))
    else $error("attach flag set outside host mode");
  otg_gap_a: assert property ((s_axi_rvalid && state_q.rd_addr == usbi_pkg::OFF_OTG_EN) |->
                              !s_axi_rdata[usbi_pkg::BIT_OTG_GAP])
    else $error("otg enable bit 1 read high");
  reset_once_a: assert property ((state_q.usb_st[usbi_pkg::BIT_RESET] && line_se0 && $past(line_se0) &&
                                  wr_lo && state_q.awaddr == usbi_pkg::OFF_USB_ST && state_q.wdata[0] &&
                                  state_q.se0_cnt == K_LIM) |=> !state_q.usb_st[usbi_pkg::BIT_RESET])
    else $error("reset flag set again during one reset");

  resume_cov: cover property ($rose(state_q.usb_st[usbi_pkg::BIT_RESUME]));
  token_cov: cover property (tok_clr && tok_cnt > 3'h1);
  write_cov: cover property (s_axi_bvalid && s_axi_bready);
  irq_cov: cover property ($rose(irq));

endmodule

//--- verification/usbi_line_model.sv
// bus side of the link: drives the decoded line levels the flag block watches
module usbi_line_model (
  input wire logic aclk,
  input wire logic [1:0] state,
  output logic line_se0 = 1'b0,
  output logic line_j = 1'b1,
  output logic bus_activity = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // state 0 quiet j, 1 k, 2 se0, 3 j with traffic; levels move just after the edge
  // k shows as neither se0 nor j
  always @(posedge aclk) begin
    line_se0 <= (state == 2'h2);
    line_j <= (state == 2'h0) || (state == 2'h3);
    bus_activity <= (state == 2'h3);
  end
endmodule

//--- verification/usbi_flags_tb.sv
`define CHK(a, b) begin \
  n_checks++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); \
  end \
end
module usbi_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, se0, lj, act;
  logic [1:0] bresp, rresp;
  logic [1:0] lstate = 2'h3;
  logic [7:0] evp = 0, errp = 0, tok = 0;
  int num_errors = 0, n_checks = 0, cyc = 0;
  // 50 MHz
  always #10 aclk = ~aclk;
  usbi_line_model u_line (.aclk(aclk), .state(lstate), .line_se0(se0), .line_j(lj), .bus_activity(act));
  usbi_flags #(.IDLE_CYC(20), .LINE_CYC(16)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .line_se0(se0), .line_j(lj), .bus_activity(act), .stall_sent_evt(evp[7]),
    .token_done_evt(evp[3]), .token_stat_in(tok), .sof_evt(evp[2]), .err_evt(errp), .id_change_evt(evp[6]),
    .ms_timer_evt(evp[5]), .session_valid_evt(evp[4]), .session_end_evt(evp[1]), .vbus_valid_evt(evp[0]),
    .irq(irq));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // a hung handshake must not stall the run forever
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    `CHK(bresp, r)
  endtask
  // read a register and compare the masked low bits
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    `CHK(rdata & m, e)
    `CHK(rresp, r)
  endtask
  task automatic pulse(input logic [7:0] v, input logic [7:0] e, input logic [7:0] t);
    @(posedge aclk);
    evp <= v;
    errp <= e;
    tok <= t;
    @(posedge aclk);
    evp <= 0;
    errp <= 0;
  endtask
  task automatic line(input logic [1:0] s, input int n);
    @(posedge aclk);
    lstate <= s;
    repeat (n) @(posedge aclk);
  endtask
  task automatic t_regs();
    rd(usbi_pkg::OFF_USB_ST, 32'hffff_ffff, 32'h0000_0000);
    rd(usbi_pkg::OFF_USB_EN, 32'hffff_ffff, 32'h0000_0000);
    wr(usbi_pkg::OFF_OTG_EN, 32'hffff_ffff);
    rd(usbi_pkg::OFF_OTG_EN, 32'hffff_ffff, 32'h0000_00fd);
    wr(usbi_pkg::OFF_USB_EN, 32'hffff_ffff);
    rd(usbi_pkg::OFF_USB_EN, 32'hffff_ffff, 32'h0000_00bf);
    rd(32'h0000_0040, 32'hffff_ffff, 32'h0000_0000, 2'h2);
    // each otg event input lands in its own status bit and clears by a one
    pulse(8'h73, 8'h00, 8'h00);
    rd(usbi_pkg::OFF_OTG_ST, 32'h0000_00cd, 32'h0000_00cd);
    wr(usbi_pkg::OFF_OTG_ST, 32'h0000_00cd);
    rd(usbi_pkg::OFF_OTG_ST, 32'h0000_00cd, 32'h0000_0000);
    wr(usbi_pkg::OFF_USB_EN, 32'h0000_0000);
  endtask
  // flags, token queue and irq gating
  task automatic t_flags();
    pulse(8'h84, 8'h00, 8'h00);
    pulse(8'h08, 8'h00, 8'h5a);
    pulse(8'h08, 8'h00, 8'h3c);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(usbi_pkg::OFF_USB_ST, 32'hffff_ffff, 32'h0000_008c);
    wr(usbi_pkg::OFF_USB_ST, 32'h0000_0004);
    rd(usbi_pkg::OFF_USB_ST, 32'hffff_ffff, 32'h0000_0088);
    rd(usbi_pkg::OFF_TOK_ST, 32'hffff_ffff, 32'h0000_005a);
    wr(usbi_pkg::OFF_USB_ST, 32'h0000_0008);
    rd(usbi_pkg::OFF_USB_ST, 32'h0000_0008, 32'h0000_0008);
    rd(usbi_pkg::OFF_TOK_ST, 32'hffff_ffff, 32'h0000_003c);
    wr(usbi_pkg::OFF_USB_EN, 32'h0000_0080);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(usbi_pkg::OFF_USB_ST, 32'h0000_0080);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    pulse(8'h00, 8'h01, 8'h00);
    rd(usbi_pkg::OFF_USB_ST, 32'h0000_0002, 32'h0000_0000);
    wr(usbi_pkg::OFF_ERR_EN, 32'h0000_0001);
    wr(usbi_pkg::OFF_USB_ST, 32'h0000_0002);
    rd(usbi_pkg::OFF_USB_ST, 32'h0000_0002, 32'h0000_0002);
  endtask
  // k just short of 2.5 us must not count, a full run must
  task automatic t_resume();
    line(2'h1, 118);
    line(2'h3, 4);
    rd(usbi_pkg::OFF_USB_ST, 32'h0000_0020, 32'h0000_0000);
    line(2'h1, 130);
    rd(usbi_pkg::OFF_USB_ST, 32'h0000_0020, 32'h0000_0020);
  endtask
  // attach, idle, reset or detach, line stable in both modes
  task automatic t_modes();
    for (int m = 1; m >= 0; m--) begin
      line(2'h3, 2);
      wr(usbi_pkg::OFF_CTRL, m);
      line(2'h0, 130);
      rd(usbi_pkg::OFF_USB_ST, 32'h0000_0050, m ? 32'h0000_0050 : 32'h0000_0010);
      wr(usbi_pkg::OFF_USB_ST, 32'h0000_00ff);
      wr(usbi_pkg::OFF_OTG_ST, 32'h0000_00ff);
      wr(usbi_pkg::OFF_USB_EN, 32'h0000_00c1);
      rd(usbi_pkg::OFF_USB_EN, 32'hffff_ffff, m ? 32'h0000_00c1 : 32'h0000_0081);
      line(2'h2, 130);
      rd(usbi_pkg::OFF_USB_ST, 32'h0000_0001, 32'h0000_0001);
      rd(usbi_pkg::OFF_OTG_ST, 32'h0000_0020, 32'h0000_0020);
      `CHK(irq, 1'b1)
      wr(usbi_pkg::OFF_USB_ST, 32'h0000_0001);
      line(2'h2, 130);
      rd(usbi_pkg::OFF_USB_ST, 32'h0000_0001, 32'h0000_0000);
    end
    // an attach caught in host mode stays stored but reads zero in device mode
    wr(usbi_pkg::OFF_CTRL, 32'h0000_0001);
    line(2'h0, 130);
    wr(usbi_pkg::OFF_CTRL, 32'h0000_0000);
    rd(usbi_pkg::OFF_USB_ST, 32'h0000_0040, 32'h0000_0000);
    wr(usbi_pkg::OFF_CTRL, 32'h0000_0001);
    rd(usbi_pkg::OFF_USB_ST, 32'h0000_0040, 32'h0000_0040);
  endtask
  // a mid-run reset must empty the queue and return flags and enables to zero
  task automatic t_reset();
    pulse(8'h88, 8'h00, 8'h77);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(usbi_pkg::OFF_USB_ST, 32'hffff_ffff, 32'h0000_0000);
    rd(usbi_pkg::OFF_TOK_ST, 32'hffff_ffff, 32'h0000_0000);
    rd(usbi_pkg::OFF_USB_EN, 32'hffff_ffff, 32'h0000_0000);
    rd(usbi_pkg::OFF_OTG_EN, 32'hffff_ffff, 32'h0000_0000);
    `CHK(irq, 1'b0)
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_flags();
    t_resume();
    t_modes();
    t_reset();
    final_report();
  end
endmodule
